//--- sdf_consts.svh
`ifndef SDF_CONSTS_SVH
`define SDF_CONSTS_SVH
// Framing format codes
`define SDF_FMT_LJ 2'h0
`define SDF_FMT_I2S 2'h1
`define SDF_FMT_RJ 2'h2
// Word width codes
`define SDF_W16 2'h0
`define SDF_W18 2'h1
`define SDF_W20 2'h2
`define SDF_W24 2'h3
// Bit clocks per half frame assumed by right-justified delays
`define SDF_HALF_FRAME 6'h20
// Right-justified frame-sync to MSB delays in bit clocks
`define SDF_RJD_16 6'h10
`define SDF_RJD_18 6'h0E
`define SDF_RJD_20 6'h0C
`define SDF_RJD_24 6'h08
// I2S and left-justified delays in bit clocks
`define SDF_I2SD 6'h01
`define SDF_LJD 6'h00
// Word lengths in bits
`define SDF_LEN_16 6'h10
`define SDF_LEN_18 6'h12
`define SDF_LEN_20 6'h14
`define SDF_LEN_24 6'h18
`endif

//--- sdf_pkg.sv
package sdf_pkg;
	typedef enum logic [1:0] {SDF_FMT_LJ_E = 2'h0, SDF_FMT_I2S_E = 2'h1,
		SDF_FMT_RJ_E = 2'h2} sdf_fmt_e;
	typedef logic [1:0] sdf_width_t;
	typedef struct packed {
		logic right;
		logic [23:0] data;
	} sdf_word_s;
endpackage

//--- sdf_fifo.sv
`timescale 1ns/1ps
module sdf_fifo
#(
	parameter int WIDTH = 25,
	parameter int DEPTH = 8
)
(
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wptr;
	logic [AW:0] rptr;
	logic do_wr;
	logic do_rd;

	// Full and empty from pointer wrap bits
	logic full;
	assign full = (wptr[AW] != rptr[AW]) && (wptr[AW-1:0] == rptr[AW-1:0]);
	assign in_ready = !full;
	assign out_valid = (wptr != rptr);
	assign out_data = mem[rptr[AW-1:0]];
	assign do_wr = in_valid && in_ready;
	assign do_rd = out_valid && out_ready;

	// Storage write
	always_ff @(posedge ref_clk)
	begin
		if (do_wr)
			mem[wptr[AW-1:0]] <= in_data;
	end

	// Pointers
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			wptr <= '0;
			rptr <= '0;
		end
		else
		begin
			if (do_wr)
				wptr <= wptr + 1'b1;
			if (do_rd)
				rptr <= rptr + 1'b1;
		end
	end
endmodule

//--- sdf_deframer.sv
`timescale 1ns/1ps
`include "sdf_consts.svh"
module sdf_deframer
#(
	parameter int FIFO_DEPTH = 8
)
(
	input wire logic ref_clk,
	input wire logic nrst,
	input wire sdf_pkg::sdf_fmt_e fmt,
	input wire sdf_pkg::sdf_width_t width_sel,
	input wire logic bit_clk,
	input wire logic frame_sync_in,
	input wire logic serial_data,
	output sdf_pkg::sdf_word_s word_out,
	output logic word_valid,
	input wire logic word_ready,
	output logic overrun
);
	import sdf_pkg::*;

	typedef enum logic [1:0] {SDF_WAIT = 2'b00, SDF_SHIFT = 2'b01}
		sdf_state_e;

	// Delay from sync edge to MSB for the chosen framing
	function automatic logic [5:0] msb_delay(sdf_fmt_e f, sdf_width_t w);
		logic [5:0] d;
		d = `SDF_I2SD;
		unique case (f)
			SDF_FMT_LJ_E: d = `SDF_LJD;
			SDF_FMT_I2S_E: d = `SDF_I2SD;
			SDF_FMT_RJ_E:
				unique case (w)
					`SDF_W16: d = `SDF_RJD_16;
					`SDF_W18: d = `SDF_RJD_18;
					`SDF_W20: d = `SDF_RJD_20;
					default: d = `SDF_RJD_24;
				endcase
			default: d = `SDF_I2SD;
		endcase
		return d;
	endfunction

	// Word length in bits
	function automatic logic [5:0] word_len(sdf_width_t w);
		logic [5:0] n;
		n = `SDF_LEN_24;
		unique case (w)
			`SDF_W16: n = `SDF_LEN_16;
			`SDF_W18: n = `SDF_LEN_18;
			`SDF_W20: n = `SDF_LEN_20;
			default: n = `SDF_LEN_24;
		endcase
		return n;
	endfunction

	logic [2:0] sync_clk;
	logic [1:0] sync_fs;
	logic [1:0] sync_sd;
	logic rise;
	logic fs_prev;
	logic fs_edge;
	logic [5:0] cnt;
	logic [5:0] bits;
	logic [23:0] shreg;
	logic chan_right;
	sdf_state_e state;
	logic push;
	sdf_word_s push_word;
	logic push_ready;
	logic fifo_valid;
	sdf_word_s fifo_data;
	logic [5:0] dly;
	logic [5:0] len;
	logic msb_now;
	logic right_lvl;

	// Two-flop synchronisers, plus a third stage for edge finding
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			sync_clk <= 3'h0;
			sync_fs <= 2'h0;
			sync_sd <= 2'h0;
		end
		else
		begin
			sync_clk <= {sync_clk[1:0], bit_clk};
			sync_fs <= {sync_fs[0], frame_sync_in};
			sync_sd <= {sync_sd[0], serial_data};
		end
	end

	// Rising bit clock; data and sync taken at this point
	assign rise = sync_clk[1] && !sync_clk[2];
	assign fs_edge = rise && (sync_fs[1] != fs_prev);
	assign dly = msb_delay(fmt, width_sel);
	assign len = word_len(width_sel);
	// MSB slot: zero delay sits on the sync edge, else counted from it
	assign msb_now = fs_edge ? (dly == 6'h0) : (cnt == dly && dly != 6'h0);
	// I2S: sync high is right; LJ and RJ: sync low is right
	assign right_lvl = sync_fs[1] ^ (fmt != SDF_FMT_I2S_E);

	// Sync level seen at previous rising edge
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			fs_prev <= 1'b0;
		else if (rise)
			fs_prev <= sync_fs[1];
	end

	// Bit counter since the last sync transition
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			cnt <= 6'h0;
		else if (fs_edge)
			cnt <= 6'h1;
		else if (rise && cnt != 6'h3F)
			cnt <= cnt + 6'h1;
	end

	// Channel tag from sync level per framing
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			chan_right <= 1'b0;
		else if (fs_edge)
			chan_right <= right_lvl;
	end

	// Word capture: start at MSB slot, stop after len bits
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state <= SDF_WAIT;
			bits <= 6'h0;
			shreg <= 24'h0;
		end
		else if (rise)
		begin
			unique case (state)
				SDF_WAIT:
					// MSB slot: on the sync edge itself for zero delay, else dly rising edges after it
					if (msb_now)
					begin
						shreg <= {23'h0, sync_sd[1]};
						bits <= 6'h1;
						state <= SDF_SHIFT;
					end
				SDF_SHIFT:
					if (bits == len)
						state <= SDF_WAIT;
					else if (fs_edge && dly == 6'h0)
					begin
						// Cut word dropped; new MSB on this edge
						shreg <= {23'h0, sync_sd[1]};
						bits <= 6'h1;
					end
					else if (fs_edge)
					begin
						// Cut word dropped; wait for the MSB slot
						state <= SDF_WAIT;
						bits <= 6'h0;
					end
					else
					begin
						shreg <= {shreg[22:0], sync_sd[1]};
						bits <= bits + 6'h1;
					end
			endcase
		end
		else if (state == SDF_SHIFT && bits == len)
			state <= SDF_WAIT;
	end

	// Hand finished word to the buffer once, left-aligned to 24 bits
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			push <= 1'b0;
			push_word <= '0;
		end
		else
		begin
			push <= (state == SDF_SHIFT) && (bits == len);
			push_word.right <= chan_right;
			push_word.data <= shreg << (6'h18 - len);
		end
	end

	// Words lost when buffer is full
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			overrun <= 1'b0;
		else if (push && !push_ready)
			overrun <= 1'b1;
	end

	sdf_fifo #(.WIDTH(25), .DEPTH(FIFO_DEPTH)) sdf_fifo_i
	(
		.ref_clk(ref_clk),
		.nrst(nrst),
		.in_valid(push),
		.in_ready(push_ready),
		.in_data(push_word),
		.out_valid(fifo_valid),
		.out_ready(word_ready || !word_valid),
		.out_data(fifo_data)
	);

	// Registered output stage
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			word_valid <= 1'b0;
			word_out <= '0;
		end
		else if (word_ready || !word_valid)
		begin
			word_valid <= fifo_valid;
			word_out <= fifo_data;
		end
	end

	AST_PUSH_ONCE: assert property (
		@(posedge ref_clk) disable iff (!nrst)
		push |=> !push) else $error("push lasted two cycles");
	AST_PUSH_CAUSE: assert property (
		@(posedge ref_clk) disable iff (!nrst)
		push |-> $past(state) == SDF_SHIFT &&
		$past(bits) == $past(len))
		else $error("word pushed before full length");
	AST_BITS_LIMIT: assert property (
		@(posedge ref_clk) disable iff (!nrst)
		bits <= 6'h18) else $error("bit count beyond 24");
	AST_CNT_EDGE: assert property (
		@(posedge ref_clk) disable iff (!nrst)
		fs_edge |=> cnt == 6'h1) else $error("counter not restarted");
	AST_I2S_TAG: assert property (
		@(posedge ref_clk) disable iff (!nrst)
		fs_edge && fmt == SDF_FMT_I2S_E
		|=> chan_right == $past(sync_fs[1]))
		else $error("i2s channel tag wrong");
	AST_RJ_TAG: assert property (
		@(posedge ref_clk) disable iff (!nrst)
		fs_edge && fmt != SDF_FMT_I2S_E
		|=> chan_right != $past(sync_fs[1]))
		else $error("lj/rj channel tag wrong");
	AST_START_SLOT: assert property (
		@(posedge ref_clk) disable iff (!nrst)
		$rose(state == SDF_SHIFT) |-> $past(rise) &&
		($past(cnt) == $past(dly) || $past(dly) == 6'h0))
		else $error("word started off its slot");
	AST_SAMPLE_RISE: assert property (
		@(posedge ref_clk) disable iff (!nrst)
		$changed(bits) && bits != 6'h0 |-> $past(rise))
		else $error("bit taken off rising edge");
	AST_OUT_HOLD: assert property (
		@(posedge ref_clk) disable iff (!nrst)
		word_valid && !word_ready |=> word_valid && $stable(word_out))
		else $error("output dropped under stall");
	AST_CUT_WORD: assert property (
		@(posedge ref_clk) disable iff (!nrst)
		fs_edge && state == SDF_SHIFT && bits != len |=> bits <= 6'h1)
		else $error("cut word kept shifting");
	COV_PUSH: cover property (@(posedge ref_clk) disable iff (!nrst) push);
	COV_CUT: cover property (@(posedge ref_clk) disable iff (!nrst)
		fs_edge && state == SDF_SHIFT && bits != len);
	COV_RJ: cover property (@(posedge ref_clk) disable iff (!nrst)
		push && fmt == SDF_FMT_RJ_E);
	COV_LJ: cover property (@(posedge ref_clk) disable iff (!nrst)
		push && fmt == SDF_FMT_LJ_E);
	COV_STALL: cover property (@(posedge ref_clk) disable iff (!nrst)
		push && !push_ready);
endmodule

//--- sdf_src_model.sv
`timescale 1ns/1ps
module sdf_src_model
(
	output logic bit_clk,
	output logic frame_sync_in,
	output logic serial_data
);
	import sdf_pkg::*;
	// Clock idles low between frames
	initial
	begin
		bit_clk = 1'b0;
		frame_sync_in = 1'b0;
		serial_data = 1'b0;
	end
	// One slot: change while clock low, device samples at the rise
	task automatic slot(input logic fs, input logic d);
		frame_sync_in = fs;
		serial_data = d;
		#16 bit_clk = 1'b1;
		#16 bit_clk = 1'b0;
	endtask
	// One full frame, left half then right half, 32 slots each
	task automatic send_frame(input sdf_fmt_e f, input logic [1:0] w,
		input logic [23:0] lw, input logic [23:0] rw);
		int len;
		int dly;
		logic lvl;
		logic d;
		logic [23:0] v;
		len = (w == 2'h3) ? 24 : 16 + 2 * w;
		dly = (f == SDF_FMT_RJ_E) ? 32 - len :
			(f == SDF_FMT_I2S_E) ? 1 : 0;
		lvl = (f != SDF_FMT_I2S_E); // Left level
		d = serial_data;
		// Lead-in so the left half opens on a sync edge
		repeat (2)
		begin
			d = ~d;
			slot(~lvl, d);
		end
		for (int h = 0; h < 2; h++)
		begin
			v = h ? rw : lw;
			for (int k = 0; k < 32; k++)
			begin
				// Junk toggles outside the word window
				if (k >= dly && k < dly + len)
					d = v[len - 1 - (k - dly)];
				else
					d = ~d;
				slot(h ? ~lvl : lvl, d);
			end
		end
		slot(lvl, ~d); // Closing slot takes sync back to the left level; right word is already done
		serial_data = d;
	endtask
endmodule

//--- sdf_deframer_tb.sv
`timescale 1ns/1ps
module sdf_deframer_tb;
	import sdf_pkg::*;
	logic ref_clk;
	logic nrst;
	logic word_ready;
	sdf_fmt_e fmt;
	sdf_width_t width_sel;
	wire logic bit_clk;
	wire logic frame_sync_in;
	wire logic serial_data;
	sdf_word_s word_out;
	logic word_valid;
	logic overrun;
	sdf_word_s got[$];
	int failures;
	int n_checks;
	sdf_deframer #(.FIFO_DEPTH(8)) sdf_deframer_i (.ref_clk(ref_clk),
		.nrst(nrst), .fmt(fmt), .width_sel(width_sel), .bit_clk(bit_clk),
		.frame_sync_in(frame_sync_in), .serial_data(serial_data),
		.word_out(word_out), .word_valid(word_valid),
		.word_ready(word_ready), .overrun(overrun));
	sdf_src_model sdf_src_model_i (.bit_clk(bit_clk),
		.frame_sync_in(frame_sync_in), .serial_data(serial_data));
	initial
	begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	// Collect accepted words
	always @(posedge ref_clk)
		if (word_valid === 1'b1 && word_ready === 1'b1)
			got.push_back(word_out);
	task automatic check(input string name, input logic [24:0] seen,
		input logic [24:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	function automatic logic [24:0] expw(input logic r, input logic [1:0] w,
		input logic [23:0] v);
		int len;
		len = (w == 2'h3) ? 24 : 16 + 2 * w;
		return {r, v << (24 - len)};
	endfunction
	// One frame in a given format and width, both words judged
	task automatic run_case(input sdf_fmt_e f, input logic [1:0] w);
		logic [23:0] lw;
		logic [23:0] rw;
		lw = 24'h9B4E2D + w;
		rw = 24'h6A1C57 - w;
		@(negedge ref_clk);
		fmt = f;
		width_sel = w;
		got.delete();
		sdf_src_model_i.send_frame(f, w, lw, rw);
		repeat (20) @(negedge ref_clk);
		check("count", 25'(got.size()), 25'h2);
		if (got.size() == 2)
		begin
			check("left", got[0], expw(1'b0, w, lw));
			check("right", got[1], expw(1'b1, w, rw));
		end
	endtask
	task automatic t_i2s();
		for (int w = 0; w < 4; w++)
			run_case(SDF_FMT_I2S_E, w[1:0]);
	endtask
	task automatic t_lj();
		for (int w = 0; w < 4; w++)
			run_case(SDF_FMT_LJ_E, w[1:0]);
	endtask
	task automatic t_rj();
		for (int w = 0; w < 4; w++)
			run_case(SDF_FMT_RJ_E, w[1:0]);
	endtask
	// Consumer stalls over ten words, then drains
	task automatic t_stall();
		@(negedge ref_clk);
		word_ready = 1'b0;
		fmt = SDF_FMT_I2S_E;
		width_sel = 2'h3;
		got.delete();
		for (int i = 0; i < 5; i++)
			sdf_src_model_i.send_frame(fmt, 2'h3, 24'(24'h100 * i),
				24'(24'h11 * i));
		repeat (10) @(negedge ref_clk);
		check("held", {24'h0, word_valid}, 25'h1);
		check("overrun", {24'h0, overrun}, 25'h1);
		word_ready = 1'b1;
		repeat (40) @(negedge ref_clk);
		// Eight in the buffer plus one held at the output
		check("kept", 25'(got.size()), 25'h9);
		for (int i = 0; i < 9 && i < got.size(); i++)
			check("drain", got[i], expw(i[0], 2'h3,
				i[0] ? 24'(24'h11 * (i / 2)) : 24'(24'h100 * (i / 2))));
	endtask
	task automatic conclude();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// Watchdog against a hang
	initial
	begin
		#200000;
		failures++;
		conclude();
	end
	initial
	begin
		failures = 0;
		n_checks = 0;
		nrst = 1'b0;
		word_ready = 1'b1;
		fmt = SDF_FMT_I2S_E;
		width_sel = 2'h0;
		// Two rising edges inside reset, release off the edge
		repeat (2) @(posedge ref_clk);
		@(negedge ref_clk);
		nrst = 1'b1;
		@(negedge ref_clk);
		check("idle", {23'h0, word_valid, overrun}, 25'h0);
		t_i2s();
		t_lj();
		t_rj();
		t_stall();
		conclude();
	end
endmodule
